/* File: hdl/sid_pkg.sv */
// Constants, types and register map of the sewing input dispatch block
package sid_pkg;

    // Input vector layout after bundling
    localparam int IDX_INHIBIT   = 0;
    localparam int IDX_TH2       = 1;
    localparam int IDX_TH1       = 2;
    localparam int IDX_TRIP      = 3;
    localparam int IDX_NOOP      = 4;
    localparam int IDX_START     = 5;
    localparam int IDX_HOME_REQ  = 6;
    localparam int IDX_HOME_KEY  = 7;
    localparam int IDX_FOOT      = 8;
    localparam int IDX_JOG       = 9;
    localparam int IDX_CLAMP     = 10;
    localparam int IDX_SEW_DONE  = 11;
    localparam int IDX_HOME_DONE = 12;
    localparam int IDX_GP0       = 13;
    localparam int NUM_GP        = 16;
    localparam int IN_W          = IDX_GP0 + NUM_GP;
    localparam int SYNC_STAGES   = 2;

    // Register bus geometry and offsets
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_STATUS   = 4'h1;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h2;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h3;
    localparam logic [3:0] OFS_ERRCODE  = 4'h4;
    localparam logic [3:0] OFS_GPO      = 4'h5;

    // Control fields and reset values
    localparam int CTRL_TH1_EN = 0;
    localparam int CTRL_TH2_EN = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // Event bits of status and mask
    localparam int EV_TRIP      = 0;
    localparam int EV_TH1       = 1;
    localparam int EV_TH2       = 2;
    localparam int EV_HOME_REJ  = 3;
    localparam int EV_START_IGN = 4;
    localparam int NUM_EV       = 5;
    localparam logic [4:0] EV_RST = 5'h00;

    // Low-air error code 025 in binary
    localparam logic [7:0] ERR_CODE_LOW_AIR = 8'h19;
    localparam logic [7:0] ERR_CODE_NONE    = 8'h00;

    typedef enum logic [1:0] {
        SID_IDLE,
        SID_SEWING,
        SID_HOMING,
        SID_ERROR
    } sid_state_type;

endpackage : sid_pkg

/* File: hdl/sid_sig_if.sv */
// Carrier of synchronised input levels and their rising edges
`timescale 1ns/1ps
interface sid_sig_if #(parameter int W = 29);
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    modport sync_src (output lvl);
    modport edge_mp  (input lvl, output rise);
    modport user     (input lvl, input rise);
endinterface : sid_sig_if

/* File: hdl/sid_sync.sv */
// Two-stage synchroniser for the bundled machine inputs
`timescale 1ns/1ps
module sid_sync #(
    parameter int W = 29
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_b_in,
    input  wire logic [W-1:0] raw_in,
    sid_sig_if.sync_src       sig
);
    logic [W-1:0] meta_q;
    logic [W-1:0] lvl_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q <= '0;
            lvl_q  <= '0;
        end else begin
            meta_q <= raw_in;
            lvl_q  <= meta_q;
        end
    end

    assign sig.lvl = lvl_q;

    // Only judged once both stages have run two edges out of reset
    a_sync_two_cycle: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) $past(rst_b_in) && $past(rst_b_in, 2) |-> lvl_q == $past(raw_in, 2)) else $error("sync delay not two cycles");
endmodule : sid_sync

/* File: hdl/sid_edge.sv */
// Rising edge finder over the synchronised input levels
`timescale 1ns/1ps
module sid_edge #(
    parameter int W = 29
) (
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    sid_sig_if.edge_mp sig
);
    logic [W-1:0] prev_q;

    // Previous level for edge comparison
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prev_q <= '0;
        end else begin
            prev_q <= sig.lvl;
        end
    end

    // Triggers fire once per off-to-on change
    assign sig.rise = sig.lvl & ~prev_q;
endmodule : sid_edge

/* File: hdl/sid_dispatch.sv */
// Top of the input dispatch: requests, inhibits, trip, mirroring, registers
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module sid_dispatch (
    input  wire logic                      sys_clk_in,
    input  wire logic                      rst_b_in,
    // Machine inputs
    input  wire logic                      home_return_inhibit_in,
    input  wire logic                      thread_sensor_ch2_in,
    input  wire logic                      thread_sensor_primary_in,
    input  wire logic                      low_air_pressure_trip_in,
    input  wire logic                      no_operation_in,
    input  wire logic                      sewing_start_input_in,
    input  wire logic                      home_return_request_in,
    input  wire logic                      home_key_in,
    input  wire logic                      presser_foot_toggle_in,
    input  wire logic                      table_jog_positive_in,
    input  wire logic                      clamp_output_in,
    input  wire logic                      sew_done_in,
    input  wire logic                      home_done_in,
    input  wire logic [15:0]               general_input_n_in,
    // Register port
    input  wire logic [sid_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic [sid_pkg::DATA_W-1:0] reg_wdata_in,
    input  wire logic                      reg_wr_in,
    input  wire logic                      reg_rd_in,
    output logic      [sid_pkg::DATA_W-1:0] reg_rdata_out,
    // Actions toward motion control and display
    output logic      [15:0]               general_output_n_out,
    output logic                           sew_start_out,
    output logic                           home_start_out,
    output logic                           abort_out,
    output logic                           error_valid_out,
    output logic      [7:0]                error_code_out,
    output logic      [1:0]                thread_break_out,
    output logic                           presser_foot_up_out,
    output logic                           table_jog_positive_out,
    output logic                           irq_out
);
    localparam int W = sid_pkg::IN_W;

    sid_sig_if #(.W(W)) sig ();

    logic [W-1:0]                raw;
    sid_pkg::sid_state_type      state_q;
    sid_pkg::sid_state_type      state_d;
    logic [1:0]                  ctrl_q;
    logic [sid_pkg::NUM_EV-1:0]  ev_stat_q;
    logic [sid_pkg::NUM_EV-1:0]  ev_mask_q;
    logic [sid_pkg::NUM_EV-1:0]  ev_set;
    logic [sid_pkg::NUM_EV-1:0]  ev_clr;
    logic                        err_q;
    logic                        trip;
    logic                        noop;
    logic                        inhibit;
    logic                        clamp;
    logic                        go_ok;
    logic                        start_rise;
    logic                        home_rise;
    logic                        foot_rise;
    logic                        sew_go;
    logic                        home_go;
    logic                        home_rej;
    logic                        start_ign;
    logic [1:0]                  th_lvl;
    logic [1:0]                  th_prev_q;
    logic [sid_pkg::DATA_W-1:0]  rd_mux;

    // Bundle the pins into one vector
    assign raw = {general_input_n_in, home_done_in, sew_done_in,
                  clamp_output_in, table_jog_positive_in,
                  presser_foot_toggle_in, home_key_in,
                  home_return_request_in, sewing_start_input_in,
                  no_operation_in, low_air_pressure_trip_in,
                  thread_sensor_primary_in, thread_sensor_ch2_in,
                  home_return_inhibit_in};

    sid_sync #(.W(W)) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .raw_in     (raw),
        .sig        (sig.sync_src)
    );

    sid_edge #(.W(W)) u_edge (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .sig        (sig.edge_mp)
    );

    // Levels and edges used by the dispatch
    assign trip       = sig.lvl[sid_pkg::IDX_TRIP];
    assign noop       = sig.lvl[sid_pkg::IDX_NOOP];
    assign inhibit    = sig.lvl[sid_pkg::IDX_INHIBIT];
    assign clamp      = sig.lvl[sid_pkg::IDX_CLAMP];
    assign start_rise = sig.rise[sid_pkg::IDX_START];
    assign home_rise  = sig.rise[sid_pkg::IDX_HOME_REQ]
                      | sig.rise[sid_pkg::IDX_HOME_KEY];
    assign foot_rise  = sig.rise[sid_pkg::IDX_FOOT];

    // Requests are only acted on when idle, free of trip and no-op
    assign go_ok     = (state_q == sid_pkg::SID_IDLE) && !err_q
                     && !trip && !noop;
    assign sew_go    = start_rise && clamp && go_ok;
    assign start_ign = start_rise && !sew_go;
    assign home_go   = home_rise && !inhibit && go_ok;
    assign home_rej  = home_rise && !(home_go && !sew_go);

    // Thread break channels gated by their enables
    assign th_lvl[0] = ctrl_q[sid_pkg::CTRL_TH1_EN]
                     && sig.lvl[sid_pkg::IDX_TH1];
    assign th_lvl[1] = ctrl_q[sid_pkg::CTRL_TH2_EN]
                     && sig.lvl[sid_pkg::IDX_TH2];

    // Operation sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            sid_pkg::SID_IDLE: begin
                if (sew_go) begin
                    state_d = sid_pkg::SID_SEWING;
                end else if (home_go) begin
                    state_d = sid_pkg::SID_HOMING;
                end
            end
            sid_pkg::SID_SEWING: begin
                if (sig.lvl[sid_pkg::IDX_SEW_DONE]) begin
                    state_d = sid_pkg::SID_IDLE;
                end
            end
            sid_pkg::SID_HOMING: begin
                if (sig.lvl[sid_pkg::IDX_HOME_DONE]) begin
                    state_d = sid_pkg::SID_IDLE;
                end
            end
            sid_pkg::SID_ERROR: begin
                state_d = sid_pkg::SID_ERROR;
            end
            default: begin
                state_d = sid_pkg::SID_IDLE;
            end
        endcase
        if (trip || err_q) begin
            state_d = sid_pkg::SID_ERROR;
        end
    end

    // State register
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= sid_pkg::SID_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Low-air error latch, cleared only by reset
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            err_q           <= 1'b0;
            error_valid_out <= 1'b0;
            error_code_out  <= sid_pkg::ERR_CODE_NONE;
            abort_out       <= 1'b0;
        end else begin
            err_q           <= err_q | trip;
            error_valid_out <= err_q | trip;
            abort_out       <= err_q | trip;
            error_code_out  <= (err_q | trip) ? sid_pkg::ERR_CODE_LOW_AIR
                                              : sid_pkg::ERR_CODE_NONE;
        end
    end

    // One-cycle start pulses toward motion control
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sew_start_out  <= 1'b0;
            home_start_out <= 1'b0;
        end else begin
            sew_start_out  <= sew_go;
            home_start_out <= home_go && !sew_go;
        end
    end

    // Presser foot toggles: first press up, next press down
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            presser_foot_up_out <= 1'b0;
        end else if (foot_rise && !noop && !trip && !err_q) begin
            presser_foot_up_out <= !presser_foot_up_out;
        end
    end

    // Positive jog follows its level while quiet
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            table_jog_positive_out <= 1'b0;
        end else begin
            table_jog_positive_out <= sig.lvl[sid_pkg::IDX_JOG] && go_ok;
        end
    end

    // General inputs mirrored to outputs
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            general_output_n_out <= 16'h0000;
        end else begin
            general_output_n_out <= sig.lvl[sid_pkg::IDX_GP0 +: 16];
        end
    end

    // Thread break outputs and their previous levels
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            thread_break_out <= 2'h0;
            th_prev_q        <= 2'h0;
        end else begin
            thread_break_out <= th_lvl;
            th_prev_q        <= th_lvl;
        end
    end

    // Control register: thread sensor enables
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_q <= sid_pkg::CTRL_RST;
        end else if (reg_wr_in && reg_addr_in == sid_pkg::OFS_CTRL) begin
            ctrl_q <= reg_wdata_in[1:0];
        end
    end

    // Event sources and write-one-to-clear strobes
    always_comb begin
        ev_set = '0;
        ev_set[sid_pkg::EV_TRIP]      = trip && !err_q;
        ev_set[sid_pkg::EV_TH1]       = th_lvl[0] && !th_prev_q[0];
        ev_set[sid_pkg::EV_TH2]       = th_lvl[1] && !th_prev_q[1];
        ev_set[sid_pkg::EV_HOME_REJ]  = home_rej;
        ev_set[sid_pkg::EV_START_IGN] = start_ign;
        ev_clr = '0;
        if (reg_wr_in && reg_addr_in == sid_pkg::OFS_IRQ_STAT) begin
            ev_clr = reg_wdata_in[sid_pkg::NUM_EV-1:0];
        end
    end

    // Sticky status: a new event wins over a clear
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ev_stat_q <= sid_pkg::EV_RST;
        end else begin
            ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
        end
    end

    // Interrupt mask
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ev_mask_q <= sid_pkg::EV_RST;
        end else if (reg_wr_in && reg_addr_in == sid_pkg::OFS_IRQ_MASK) begin
            ev_mask_q <= reg_wdata_in[sid_pkg::NUM_EV-1:0];
        end
    end

    // Interrupt level from the next status value
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(((ev_stat_q & ~ev_clr) | ev_set) & ev_mask_q);
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        case (reg_addr_in)
            sid_pkg::OFS_CTRL:     rd_mux[1:0] = ctrl_q;
            sid_pkg::OFS_STATUS: begin
                rd_mux[0] = (state_q == sid_pkg::SID_SEWING);
                rd_mux[1] = (state_q == sid_pkg::SID_HOMING);
                rd_mux[2] = err_q;
                rd_mux[3] = presser_foot_up_out;
                rd_mux[4] = noop;
                rd_mux[5] = clamp;
            end
            sid_pkg::OFS_IRQ_STAT: rd_mux[sid_pkg::NUM_EV-1:0] = ev_stat_q;
            sid_pkg::OFS_IRQ_MASK: rd_mux[sid_pkg::NUM_EV-1:0] = ev_mask_q;
            sid_pkg::OFS_ERRCODE:  rd_mux[7:0] = error_code_out;
            sid_pkg::OFS_GPO:      rd_mux = general_output_n_out;
            default:               rd_mux = '0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_mux : '0;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_home_inhibit_block: assert property (home_rise && inhibit |=> !home_start_out) else $error("home started while inhibited");

    a_th2_gated: assert property (!ctrl_q[sid_pkg::CTRL_TH2_EN] |=> !thread_break_out[1]) else $error("channel 2 break while disabled");

    a_th1_detect: assert property (ctrl_q[sid_pkg::CTRL_TH1_EN] && sig.lvl[sid_pkg::IDX_TH1] |=> thread_break_out[0]) else $error("primary break missed");

    a_trip_abort: assert property (trip |=> abort_out && error_valid_out && error_code_out == 8'h19 && !sew_start_out) else $error("trip not aborting");

    a_error_held: assert property (error_valid_out |=> error_valid_out && abort_out ##1 state_q == sid_pkg::SID_ERROR) else $error("error cleared without reset");

    a_gpo_mirror: assert property ($past(sig.lvl[sid_pkg::IDX_GP0 +: 16]) == general_output_n_out) else $error("general output mismatch");

    a_noop_quiet: assert property (noop |=> !sew_start_out && !home_start_out && !table_jog_positive_out) else $error("operation during no-op");

    a_start_go: assert property (start_rise && clamp && go_ok |=> sew_start_out && state_q == sid_pkg::SID_SEWING) else $error("start not taken");

    a_start_clamp: assert property (start_rise && !clamp |=> !sew_start_out) else $error("start taken with clamp off");

    a_home_go: assert property (home_rise && !inhibit && go_ok && !sew_go |=> home_start_out) else $error("home not started");

    a_home_busy: assert property (home_rise && state_q != sid_pkg::SID_IDLE |=> !home_start_out && ev_stat_q[sid_pkg::EV_HOME_REJ]) else $error("busy home accepted");

    a_foot_toggle: assert property (foot_rise && !noop && !trip && !err_q |=> presser_foot_up_out != $past(presser_foot_up_out)) else $error("foot did not toggle");

    a_foot_down: assert property (presser_foot_up_out && foot_rise && !noop && !trip && !err_q |=> !presser_foot_up_out) else $error("foot not lowered");

    a_jog_follow: assert property (sig.lvl[sid_pkg::IDX_JOG] && go_ok |=> table_jog_positive_out) else $error("jog not driven");

    c_sew_cycle: cover property (sew_start_out ##[1:100] state_q == sid_pkg::SID_IDLE);
    c_home_cycle: cover property (home_start_out ##[1:100] state_q == sid_pkg::SID_IDLE);
    c_trip_seen: cover property (trip ##1 abort_out);
    c_foot_twice: cover property (presser_foot_up_out ##[1:20] !presser_foot_up_out);
endmodule : sid_dispatch

/* File: testbench/sid_machine.sv */
// Motion-side model: answers each start pulse with a finish level
`timescale 1ns/1ps
module sid_machine #(
    parameter int RUN_CYC = 60
) (
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    input  wire logic sew_start_in,
    input  wire logic home_start_in,
    output logic      sew_done_out,
    output logic      home_done_out
);
    int   cnt_q;
    logic kind_q;

    // Run timer, loaded by a start; 1 in kind_q means homing
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q  <= 0;
            kind_q <= 1'b0;
        end else if (sew_start_in || home_start_in) begin
            cnt_q  <= RUN_CYC + 4;
            kind_q <= home_start_in;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
    end

    // Finish stays up four cycles so it survives the input synchroniser
    assign sew_done_out  = (cnt_q inside {[1:4]}) && !kind_q;
    assign home_done_out = (cnt_q inside {[1:4]}) && kind_q;
endmodule : sid_machine

/* File: testbench/sewing_input_signal_dispatch_bench.sv */
// Self-checking bench of the sewing input dispatch block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module sewing_input_signal_dispatch_bench;
    logic        clk;
    logic        rst_b;
    logic        inh, th2, th1, trip, noop, jog, clamp, sdone, hdone;
    logic        wr, rd, sew_go, home_go, abort, err_v, foot_up, jog_o, irq;
    logic [3:0]  trg;
    logic [1:0]  brk;
    logic [7:0]  ecode;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, gpi, gpo;
    int          bad_count = 0, total_checks = 0, cyc = 0;
    int          n_sew = 0, n_home = 0;

    sid_dispatch DUT (
        .sys_clk_in(clk), .rst_b_in(rst_b),
        .home_return_inhibit_in(inh), .thread_sensor_ch2_in(th2),
        .thread_sensor_primary_in(th1), .low_air_pressure_trip_in(trip),
        .no_operation_in(noop), .sewing_start_input_in(trg[0]),
        .home_return_request_in(trg[1]), .home_key_in(trg[2]),
        .presser_foot_toggle_in(trg[3]), .table_jog_positive_in(jog),
        .clamp_output_in(clamp), .sew_done_in(sdone), .home_done_in(hdone),
        .general_input_n_in(gpi), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .general_output_n_out(gpo), .sew_start_out(sew_go),
        .home_start_out(home_go), .abort_out(abort),
        .error_valid_out(err_v), .error_code_out(ecode),
        .thread_break_out(brk), .presser_foot_up_out(foot_up),
        .table_jog_positive_out(jog_o), .irq_out(irq));

    sid_machine #(.RUN_CYC(60)) machine (
        .sys_clk_in(clk), .rst_b_in(rst_b), .sew_start_in(sew_go),
        .home_start_in(home_go), .sew_done_out(sdone),
        .home_done_out(hdone));

    // Clock of 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Start pulse counters and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (sew_go === 1'b1) n_sew <= n_sew + 1;
        if (home_go === 1'b1) n_home <= n_home + 1;
        if (cyc == 6000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // One input trigger held three cycles, then released and settled
    task automatic pulse(input int i);
        @(posedge clk) trg[i] <= 1'b1;
        repeat (3) @(posedge clk);
        trg[i] <= 1'b0;
        tick(4);
    endtask : pulse

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_chk(input string nm, input logic [3:0] a,
                          input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(nm, e, rdata)
    endtask : rd_chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // Test sequence
    initial begin
        {inh, th2, th1, trip, noop, jog, clamp, wr, rd} = '0;
        trg = 4'h0; addr = 4'h0; wdata = 16'h0000; gpi = 16'h0000;
        rst_b = 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk("ctrl", sid_pkg::OFS_CTRL, 16'h0000);
        rd_chk("unmapped", 4'hF, 16'h0000);
        @(posedge clk) gpi <= 16'hA5C3;
        tick(4);
        `CHK("gpo", 16'hA5C3, gpo)
        rd_chk("gpo_reg", sid_pkg::OFS_GPO, 16'hA5C3);
        $display("test reset and mirror done");
        pulse(0);
        `CHK("sew_no_clamp", 0, n_sew)
        rd_chk("ign_stat", sid_pkg::OFS_IRQ_STAT, 16'h0010);
        `CHK("irq_off", 1'b0, irq)
        wr_reg(sid_pkg::OFS_IRQ_MASK, 16'h001F);
        tick(2);
        `CHK("irq_on", 1'b1, irq)
        wr_reg(sid_pkg::OFS_IRQ_STAT, 16'h001F);
        tick(1);
        `CHK("irq_clr", 1'b0, irq)
        wr_reg(sid_pkg::OFS_IRQ_MASK, 16'h0000);
        rd_chk("stat_clr", sid_pkg::OFS_IRQ_STAT, 16'h0000);
        $display("test clamp off and irq done");
        @(posedge clk) clamp <= 1'b1;
        pulse(0);
        `CHK("sew_go", 1, n_sew)
        rd_chk("sewing", sid_pkg::OFS_STATUS, 16'h0021);
        pulse(1);
        `CHK("home_busy", 0, n_home)
        rd_chk("rej_stat", sid_pkg::OFS_IRQ_STAT, 16'h0008);
        tick(80);
        rd_chk("idle", sid_pkg::OFS_STATUS, 16'h0020);
        $display("test sewing start done");
        @(posedge clk) inh <= 1'b1;
        pulse(1);
        pulse(2);
        `CHK("home_inh", 0, n_home)
        @(posedge clk) inh <= 1'b0;
        pulse(2);
        `CHK("home_go", 1, n_home)
        tick(80);
        @(posedge clk) noop <= 1'b1;
        pulse(0);
        pulse(3);
        `CHK("noop_sew", 1, n_sew)
        `CHK("noop_foot", 1'b0, foot_up)
        rd_chk("noop_stat", sid_pkg::OFS_STATUS, 16'h0030);
        @(posedge clk) noop <= 1'b0;
        pulse(3);
        `CHK("foot_up", 1'b1, foot_up)
        pulse(3);
        `CHK("foot_down", 1'b0, foot_up)
        @(posedge clk) jog <= 1'b1;
        tick(4);
        `CHK("jog_on", 1'b1, jog_o)
        @(posedge clk) jog <= 1'b0;
        tick(4);
        `CHK("jog_off", 1'b0, jog_o)
        $display("test home, no-op, foot, jog done");
        @(posedge clk) {th1, th2} <= 2'b11;
        tick(4);
        `CHK("brk_off", 2'b00, brk)
        wr_reg(sid_pkg::OFS_CTRL, 16'h0001);
        tick(2);
        `CHK("brk_th1", 2'b01, brk)
        wr_reg(sid_pkg::OFS_CTRL, 16'h0003);
        tick(2);
        `CHK("brk_both", 2'b11, brk)
        $display("test thread sensors done");
        @(posedge clk) trip <= 1'b1;
        tick(4);
        `CHK("abort", 1'b1, abort)
        `CHK("ecode", sid_pkg::ERR_CODE_LOW_AIR, ecode)
        @(posedge clk) trip <= 1'b0;
        pulse(0);
        `CHK("err_held", 1'b1, err_v)
        `CHK("trip_sew", 1, n_sew)
        rd_chk("err_reg", sid_pkg::OFS_ERRCODE,
               {8'h00, sid_pkg::ERR_CODE_LOW_AIR});
        rd_chk("err_stat", sid_pkg::OFS_STATUS, 16'h0024);
        @(posedge clk) rst_b <= 1'b0;
        tick(4);
        @(posedge clk) rst_b <= 1'b1;
        tick(2);
        `CHK("err_clr", 1'b0, err_v)
        `CHK("ecode_clr", 8'h00, ecode)
        $display("test low-air trip done");
        report_and_stop();
    end
endmodule : sewing_input_signal_dispatch_bench
